// ===== flash_self_program_control.sv
// flash self-programming control: registers, unlock, launch, regulator
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"

module flash_self_program_control
  import flash_ctrl_pkg::*;
(
  // clock, enable, resets
  input wire logic CLK_SYS,
  input wire logic CE,
  input wire logic RST,
  input wire logic SYS_RST,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [4:0] S_AXI_AWADDR,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // flash array
  output logic FLASH_START,
  output logic FLASH_ERASE,
  output logic [23:0] FLASH_ADDR,
  input wire logic FLASH_DONE,
  // cpu and power control
  output logic CPU_STALL,
  input wire logic POWER_SAVE_REQ,
  output logic POWER_SAVE_GRANT,
  input wire logic IDLE_MODE,
  output logic REG_STANDBY,
  output logic FLASH_READY
);

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic reg_e reg_sel(input logic [4:0] addr);
    reg_e r;
    r = REG_NONE;
    unique case ({addr[4:2], 2'b00})
      `FSP_OFF_CTL: r = REG_CTL;
      `FSP_OFF_ADR_HI: r = REG_HI;
      `FSP_OFF_ADR_LO: r = REG_LO;
      `FSP_OFF_KEY: r = REG_KEY;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction

  function automatic logic op_valid(input logic [3:0] op);
    return (op == `FSP_OP_ERASE) || (op == `FSP_OP_PROG);
  endfunction

  state_s q;
  state_s d;
  reg_e wsel;
  reg_e rsel;
  logic do_wr;
  logic do_rd;
  logic start_try;
  logic launch_ok;
  logic [3:0] new_op;
  logic [23:0] tgt_addr;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    wsel = reg_sel(q.aw_addr);
    rsel = reg_sel(S_AXI_ARADDR);
    do_wr = q.aw_got && q.w_got && !q.bvalid;
    do_rd = S_AXI_ARVALID && q.arready;
    new_op = q.w_strb[0] ? q.w_data[`FSP_CTL_OP_HI:0] : q.ctl_op;
    tgt_addr = {q.adr_hi, q.adr_lo};
    start_try = do_wr && (wsel == REG_CTL) && q.w_strb[1] && q.w_data[`FSP_CTL_START];
    launch_ok = start_try && !q.ctl_start && (q.key == KEY_OPEN)
                && q.w_data[`FSP_CTL_EN] && op_valid(new_op);
    d.flash_start = 1'b0;
    d.pwr_grant = 1'b0;

    // write address and data are taken independently
    if (S_AXI_AWVALID && q.awready)
    begin
      d.aw_got = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
      d.awready = 1'b0;
    end
    if (S_AXI_WVALID && q.wready)
    begin
      d.w_got = 1'b1;
      d.w_data = S_AXI_WDATA[15:0];
      d.w_strb = S_AXI_WSTRB[1:0];
      d.wready = 1'b0;
    end

    // register write
    if (do_wr)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (wsel == REG_NONE) ? `FSP_RESP_SLVERR : `FSP_RESP_OKAY;
      d.key = KEY_LOCKED;
      unique case (wsel)
        REG_CTL:
        begin
          if (q.w_strb[1])
          begin
            d.ctl_en = q.w_data[`FSP_CTL_EN];
            d.ctl_err = q.w_data[`FSP_CTL_ERR];
            d.ctl_sidl = q.w_data[`FSP_CTL_SIDL];
          end
          if (q.w_strb[0])
          begin
            d.ctl_op = q.w_data[`FSP_CTL_OP_HI:0];
          end
          // a zero written to start is simply dropped
          if (start_try)
          begin
            d.ctl_err = 1'b1;
          end
          if (launch_ok)
          begin
            d.ctl_start = 1'b1;
            d.seq = SEQ_RUN;
            d.flash_start = 1'b1;
            d.flash_erase = (new_op == `FSP_OP_ERASE);
            d.flash_addr = (new_op == `FSP_OP_ERASE) ? tgt_addr : (tgt_addr & `FSP_PROG_ALIGN);
            d.cpu_stall = 1'b1;
          end
        end
        REG_HI:
        begin
          if (q.w_strb[0])
          begin
            d.adr_hi = q.w_data[7:0];
          end
        end
        REG_LO:
        begin
          if (q.w_strb[0])
          begin
            d.adr_lo[7:0] = q.w_data[7:0];
          end
          if (q.w_strb[1])
          begin
            d.adr_lo[15:8] = q.w_data[15:8];
          end
        end
        REG_KEY:
        begin
          if (q.w_strb[0] && (q.w_data[7:0] == `FSP_KEY_FIRST))
          begin
            d.key = KEY_HALF;
          end
          else if (q.w_strb[0] && (q.w_data[7:0] == `FSP_KEY_SECOND) && (q.key == KEY_HALF))
          begin
            d.key = KEY_OPEN;
          end
        end
        REG_NONE:
        begin
          d.key = KEY_LOCKED;
        end
      endcase
    end
    if (q.bvalid && S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // register read; a read between key writes also relocks
    if (do_rd)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = (rsel == REG_NONE) ? `FSP_RESP_SLVERR : `FSP_RESP_OKAY;
      d.key = KEY_LOCKED;
      unique case (rsel)
        REG_CTL: d.rdata = {16'h0000, q.ctl_start, q.ctl_en, q.ctl_err, q.ctl_sidl, 8'h00, q.ctl_op};
        REG_HI: d.rdata = {24'h000000, q.adr_hi};
        REG_LO: d.rdata = {16'h0000, q.adr_lo};
        REG_KEY: d.rdata = 32'h00000000;
        REG_NONE: d.rdata = 32'h00000000;
      endcase
    end
    if (q.rvalid && S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // self-timed operation ends when the array reports done
    if ((q.seq == SEQ_RUN) && FLASH_DONE)
    begin
      d.seq = SEQ_IDLE;
      d.ctl_start = 1'b0;
      // a start attempt in the same cycle keeps the flag set
      if (!start_try)
      begin
        d.ctl_err = 1'b0;
      end
      d.cpu_stall = 1'b0;
    end

    // power save is refused while the array is busy
    d.pwr_grant = POWER_SAVE_REQ && (q.seq == SEQ_IDLE) && !q.ctl_start;

    // regulator standby in idle and wake-up delay
    if (IDLE_MODE && q.ctl_sidl)
    begin
      d.reg_standby = 1'b1;
      d.flash_ready = 1'b0;
      d.wake_cnt = 8'h00;
    end
    else if (q.reg_standby)
    begin
      d.reg_standby = 1'b0;
      d.wake_cnt = 8'(`FSP_WAKE_CYCLES);
    end
    else if (q.wake_cnt != 8'h00)
    begin
      d.wake_cnt = q.wake_cnt - 8'h01;
      d.flash_ready = (q.wake_cnt == 8'h01);
    end

    // a system reset drops only the unlock progress
    if (SYS_RST)
    begin
      d.key = KEY_LOCKED;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // RST is the power-on reset; control bits see no other reset
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.flash_ready <= 1'b1;
    end
    else if (CE)
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign FLASH_START = q.flash_start;
  assign FLASH_ERASE = q.flash_erase;
  assign FLASH_ADDR = q.flash_addr;
  assign CPU_STALL = q.cpu_stall;
  assign POWER_SAVE_GRANT = q.pwr_grant;
  assign REG_STANDBY = q.reg_standby;
  assign FLASH_READY = q.flash_ready;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  start_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && (q.seq == SEQ_RUN) && FLASH_DONE |=> !q.ctl_start && !CPU_STALL)
    else $error("start bit not cleared at completion");

  start_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    q.ctl_start && !(CE && FLASH_DONE) |=> q.ctl_start)
    else $error("start bit cleared without completion");

  enable_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    FLASH_START |-> q.ctl_en && q.ctl_start)
    else $error("operation launched while disabled");

  key_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    FLASH_START |-> $past(q.key == KEY_OPEN))
    else $error("operation launched without unlock");

  error_flag_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && start_try |=> q.ctl_err)
    else $error("start attempt did not flag error");

  op_decode_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    FLASH_START |-> op_valid(q.ctl_op) && (FLASH_ERASE == (q.ctl_op == `FSP_OP_ERASE)))
    else $error("reserved operation launched");

  prog_align_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    FLASH_START && !FLASH_ERASE |-> (FLASH_ADDR[1:0] == 2'b00))
    else $error("program address misaligned");

  pwrsave_ignore_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && (q.seq == SEQ_RUN) |=> !POWER_SAVE_GRANT)
    else $error("power save granted during operation");

  standby_idle_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && IDLE_MODE && q.ctl_sidl |=> REG_STANDBY && !FLASH_READY)
    else $error("regulator not in standby during idle");

  wake_delay_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && REG_STANDBY && !IDLE_MODE |=> !FLASH_READY [*2])
    else $error("flash ready before wake delay");

  stall_run_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.seq == SEQ_RUN) |-> CPU_STALL)
    else $error("cpu not stalled during operation");

  access_relock_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && (do_rd || (do_wr && (wsel != REG_KEY))) |=> (q.key == KEY_LOCKED))
    else $error("unlock survived an intervening access");

  erase_page_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    FLASH_START && FLASH_ERASE |-> (FLASH_ADDR == {q.adr_hi, q.adr_lo}))
    else $error("erase address differs from target registers");

endmodule
`default_nettype wire

// ===== flash_ctrl_defines.svh
// constants for the flash self-programming control block
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets on the bus
// ------------------------------------------------------------
`define FSP_OFF_CTL 5'h00
`define FSP_OFF_ADR_HI 5'h04
`define FSP_OFF_ADR_LO 5'h08
`define FSP_OFF_KEY 5'h0c

// ------------------------------------------------------------
// control register fields, operation codes, unlock keys and program alignment mask
// ------------------------------------------------------------
`define FSP_CTL_START 15
`define FSP_CTL_EN 14
`define FSP_CTL_ERR 13
`define FSP_CTL_SIDL 12
`define FSP_CTL_OP_HI 3
`define FSP_OP_ERASE 4'h3
`define FSP_OP_PROG 4'h1
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa
`define FSP_PROG_ALIGN 24'hfffffc

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// regulator wake delay
// ------------------------------------------------------------
`define FSP_CLK_PERIOD_NS 100
`define FSP_WAKE_DELAY_NS 20000
`define FSP_WAKE_CYCLES ((`FSP_WAKE_DELAY_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

// ===== flash_ctrl_pkg.sv
// types of the flash self-programming control block
`default_nettype none
`include "flash_ctrl_defines.svh"
package flash_ctrl_pkg;

  typedef enum logic {SEQ_IDLE = 1'b0, SEQ_RUN = 1'b1} seq_e;
  typedef enum logic [1:0] {KEY_LOCKED = 2'b00, KEY_HALF = 2'b01, KEY_OPEN = 2'b10} key_e;
  typedef enum logic [2:0] {REG_CTL = 3'b000, REG_HI = 3'b001, REG_LO = 3'b010, REG_KEY = 3'b011,
                            REG_NONE = 3'b100} reg_e;

  typedef struct packed {
    seq_e seq;
    key_e key;
    logic ctl_start;
    logic ctl_en;
    logic ctl_err;
    logic ctl_sidl;
    logic [3:0] ctl_op;
    logic [7:0] adr_hi;
    logic [15:0] adr_lo;
    logic aw_got;
    logic w_got;
    logic [4:0] aw_addr;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic flash_start;
    logic flash_erase;
    logic [23:0] flash_addr;
    logic cpu_stall;
    logic pwr_grant;
    logic reg_standby;
    logic flash_ready;
    logic [7:0] wake_cnt;
  } state_s;

endpackage
`default_nettype wire

// ===== flash_self_program_control_tb_top.sv
// self-checking bench for the flash self-programming control block
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"
module flash_self_program_control_tb_top;
  import flash_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sys_rst = 1'b0;
  logic ce = 1'b1;
  logic done = 1'b0;
  logic pwr_req = 1'b0;
  logic idle = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, f_start, f_erase, stall, grant, standby, f_ready;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [23:0] f_addr, last_addr;
  logic last_erase;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int starts = 0;
  int grants = 0;

  always #50 clk = ~clk;

  flash_self_program_control flash_self_program_control_inst (
    .CLK_SYS(clk), .CE(ce), .RST(rst), .SYS_RST(sys_rst),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .FLASH_START(f_start), .FLASH_ERASE(f_erase), .FLASH_ADDR(f_addr), .FLASH_DONE(done),
    .CPU_STALL(stall), .POWER_SAVE_REQ(pwr_req), .POWER_SAVE_GRANT(grant), .IDLE_MODE(idle),
    .REG_STANDBY(standby), .FLASH_READY(f_ready)
  );

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_bit(input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // ------------------------------------------------------------
  // monitors and hang guard
  // ------------------------------------------------------------
  // one-cycle outputs are counted here so no pulse slips past a busy task
  always @(posedge clk)
  begin
    cyc++;
    if (f_start === 1'b1)
    begin
      starts++;
      last_addr = f_addr;
      last_erase = f_erase;
    end
    if (grant === 1'b1)
      grants++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // bus master
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0, d};
    wstrb <= 4'h3;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic axi_rd(input logic [4:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask

  task automatic unlock();
    axi_wr(`FSP_OFF_KEY, 16'h0055);
    axi_wr(`FSP_OFF_KEY, 16'h00aa);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_regs();
    axi_rd(`FSP_OFF_CTL);
    chk_word(32'h0, rd);
    axi_wr(`FSP_OFF_CTL, 16'h0ff0);
    axi_rd(`FSP_OFF_CTL);
    chk_word(32'h0, rd);
    axi_wr(`FSP_OFF_KEY, 16'h0055);
    axi_rd(`FSP_OFF_KEY);
    chk_word(32'h0, rd);
    axi_rd(5'h10);
    chk_word({30'h0, `FSP_RESP_SLVERR}, {30'h0, resp});
    axi_wr(5'h14, 16'h1234);
    chk_word({30'h0, `FSP_RESP_SLVERR}, {30'h0, resp});
  endtask

  task automatic t_addr_regs();
    axi_wr(`FSP_OFF_ADR_HI, 16'h0012);
    axi_wr(`FSP_OFF_ADR_LO, 16'h3457);
    axi_rd(`FSP_OFF_ADR_HI);
    chk_word(32'h12, rd);
    axi_rd(`FSP_OFF_ADR_LO);
    chk_word(32'h3457, rd);
  endtask

  // mode 0 locked, 1 unlocked, 2 unlocked then a stray read
  task automatic t_refused(input logic [15:0] ctl, input int mode);
    int n;
    n = starts;
    axi_wr(`FSP_OFF_CTL, 16'h0000);
    if (mode > 0)
      unlock();
    if (mode == 2)
      axi_rd(`FSP_OFF_ADR_HI);
    axi_wr(`FSP_OFF_CTL, ctl);
    repeat (3) @(posedge clk);
    chk_word(n, starts);
    axi_rd(`FSP_OFF_CTL);
    chk_word(32'h2000, rd & 32'ha000);
  endtask

  task automatic t_launch(input logic [15:0] ctl, input logic [23:0] addr, input logic erase);
    int n;
    int g;
    n = starts;
    g = grants;
    unlock();
    axi_wr(`FSP_OFF_CTL, ctl);
    // quiet slots also let the start monitor count before it is read
    repeat (2) @(posedge clk);
    chk_bit(1'b1, stall);
    chk_word(n + 1, starts);
    chk_word({8'h0, addr}, {8'h0, last_addr});
    chk_bit(erase, last_erase);
    pwr_req <= 1'b1;
    @(posedge clk);
    pwr_req <= 1'b0;
    // error flag kept up by this write so only completion can clear it
    axi_wr(`FSP_OFF_CTL, (ctl & 16'h7fff) | 16'h2000);
    axi_rd(`FSP_OFF_CTL);
    chk_word(32'ha000, rd & 32'ha000);
    chk_word(g, grants);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(1'b0, stall);
    axi_rd(`FSP_OFF_CTL);
    chk_word({16'h0, ctl & 16'h5fff}, rd);
  endtask

  task automatic t_power_idle();
    int g;
    int n;
    g = grants;
    // a request while the clock enable is low must leave all state frozen
    ce <= 1'b0;
    pwr_req <= 1'b1;
    @(posedge clk);
    pwr_req <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    chk_word(g, grants);
    pwr_req <= 1'b1;
    @(posedge clk);
    pwr_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk_word(g + 1, grants);
    axi_wr(`FSP_OFF_CTL, 16'h5003);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    axi_rd(`FSP_OFF_CTL);
    chk_word(32'h5003, rd);
    axi_wr(`FSP_OFF_CTL, 16'h4003);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(1'b0, standby);
    chk_bit(1'b1, f_ready);
    idle <= 1'b0;
    axi_wr(`FSP_OFF_CTL, 16'h5003);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(1'b1, standby);
    chk_bit(1'b0, f_ready);
    idle <= 1'b0;
    n = 0;
    while (f_ready !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk_bit(1'b0, standby);
    // edge counting is inexact by a cycle early or two late, so a small window is allowed
    chk_bit(1'b1, n >= `FSP_WAKE_CYCLES - 1 && n <= `FSP_WAKE_CYCLES + 2);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_addr_regs();
    t_refused(16'hc003, 0);
    t_refused(16'hc003, 2);
    t_refused(16'h8003, 1);
    t_refused(16'hc002, 1);
    t_refused(16'hc00f, 1);
    t_launch(16'hc003, 24'h123457, 1'b1);
    t_launch(16'hc001, 24'h123454, 1'b0);
    t_power_idle();
    give_verdict();
  end
endmodule
`default_nettype wire
